// ===== shared/dpg_gpio_map.vh
// register map, field positions and reset values of the dual-port gpio block
`ifndef DPG_GPIO_MAP_VH
`define DPG_GPIO_MAP_VH

// ============================================================
// register indices (byte address = index * 4)
`define DPG_IDX_LOW_PORT_OUT   8'h90
`define DPG_IDX_LOW_PORT_DIR   8'h91
`define DPG_IDX_LOW_PORT_IN    8'h92
`define DPG_IDX_LOW_PORT_PULL  8'h93
`define DPG_IDX_HIGH_PORT_OUT  8'hB0
`define DPG_IDX_HIGH_PORT_DIR  8'hEB
`define DPG_IDX_HIGH_PORT_IN   8'hEC
`define DPG_IDX_HIGH_PORT_PULL 8'hED
`define DPG_IDX_WAKE_MASK      8'hF0
`define DPG_IDX_IRQ_CTRL       8'hF1
`define DPG_IDX_ALT_CTRL       8'hF2

// ============================================================
// reset values
`define DPG_RST_LOW_OUT        8'hFF
`define DPG_RST_LOW_DIR        8'hFF
`define DPG_RST_LOW_PULL       8'h00
`define DPG_RST_HIGH_OUT       2'h3
`define DPG_RST_HIGH_DIR       2'h3
`define DPG_RST_HIGH_PULL      2'h0
`define DPG_RST_WAKE_MASK      8'hFF
`define DPG_RST_IRQ_CTRL       4'h0
`define DPG_RST_ALT_CTRL       8'h00

// ============================================================
// field positions
`define DPG_IRQ_ZERO_EN        0
`define DPG_IRQ_ZERO_EDGE      1
`define DPG_IRQ_ONE_EN         2
`define DPG_IRQ_ONE_EDGE       3
`define DPG_IRQ_ZERO_FLAG      4
`define DPG_IRQ_ONE_FLAG       5
`define DPG_ALT_SPI_EN         0
`define DPG_ALT_T1_COUNT_SEL   6
`define DPG_ALT_T1_GATE        7

// ============================================================
// bus answers
`define DPG_RESP_OKAY          2'h0
`define DPG_RESP_SLVERR        2'h2

`endif

// ===== core/dpg_gpio_top.v
// dual-port gpio with spi, wake-up, external irq and timer pin functions
`timescale 1ns/1ps
`include "dpg_gpio_map.vh"

module dpg_gpio_top (
    input  wire        core_clk,
    input  wire        rst_n,
    // axi4-lite register slave
    input  wire [9:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [9:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // pads PP0..PP9
    input  wire [9:0]  pinIn,
    output wire [9:0]  pinOut,
    output wire [9:0]  pinOe,
    output wire [9:0]  pullUpEn,
    output wire [9:0]  pullDownEn,
    // spi peripheral side, bit 0..3 = cs, miso, mosi, clk
    input  wire [3:0]  spiOut,
    input  wire [3:0]  spiOe,
    output wire [3:0]  spiIn,
    // power-down wake-up
    input  wire        powerDown,
    output wire        wakeReq,
    // interrupt controller side
    input  wire        irqZeroAck,
    input  wire        irqOneAck,
    output wire        irqZeroFlag,
    output wire        irqOneFlag,
    // timer one side
    output wire        timerOneGateOk,
    output wire        timerOneCountTick
);

    // ============================================================
    // register storage
    reg  [7:0]  lowOut_q;       // low port data out
    reg  [7:0]  lowDir_q;       // low port direction, 1 = input
    reg  [7:0]  lowPull_q;      // low port pull select
    reg  [1:0]  highOut_q;      // high port data out, bits 1:0 only
    reg  [1:0]  highDir_q;      // high port direction
    reg  [1:0]  highPull_q;     // high port pull select
    reg  [7:0]  wakeMask_q;     // 0 enables the wake source
    reg  [3:0]  irqCtrl_q;      // enables and edge selects
    reg  [7:0]  altCtrl_q;      // spi enable, timer one selects
    reg         irqZeroFlag_q;  // interrupt zero pending
    reg         irqOneFlag_q;   // interrupt one pending

    // ============================================================
    // input synchroniser and spike filter
    reg  [9:0]  syncA_q;        // first stage, read only by syncB_q
    reg  [9:0]  syncB_q;
    reg  [9:0]  syncC_q;
    reg  [9:0]  pinFilt_q;      // filtered pin level
    reg  [9:0]  pinPrev_q;      // filtered level one cycle ago

    // ============================================================
    // bus slave state
    reg         awHeld_q;       // write address captured
    reg         wHeld_q;        // write data captured
    reg  [7:0]  awIdx_q;        // captured write index
    reg  [7:0]  wByte_q;        // captured low data byte
    reg         wLane_q;        // low byte lane strobed

    // ============================================================
    // combined per-pin views
    // bits 7:0 come from the low port and bits 9:8 from the two
    // implemented bits of the high port, so every pin-wide vector
    // below is indexed directly by the pad number
    wire [9:0]  pinDir  = {highDir_q, lowDir_q};
    wire [9:0]  pinData = {highOut_q, lowOut_q};
    wire [9:0]  pinPull = {highPull_q, lowPull_q};
    wire        spiEn   = altCtrl_q[`DPG_ALT_SPI_EN];

    // ------------------------------------------------------------
    // true if the index names one of the mapped registers; holes
    // answer with an error so stray software accesses are visible
    function isMapped;
        input [7:0] idx;
        begin
            case (idx)
                `DPG_IDX_LOW_PORT_OUT, `DPG_IDX_LOW_PORT_DIR,
                `DPG_IDX_LOW_PORT_IN, `DPG_IDX_LOW_PORT_PULL,
                `DPG_IDX_HIGH_PORT_OUT, `DPG_IDX_HIGH_PORT_DIR,
                `DPG_IDX_HIGH_PORT_IN, `DPG_IDX_HIGH_PORT_PULL,
                `DPG_IDX_WAKE_MASK, `DPG_IDX_IRQ_CTRL,
                `DPG_IDX_ALT_CTRL: isMapped = 1'b1;
                default:           isMapped = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // next value of an interrupt flag; set wins over any clear
    function irqNext;
        input setEv;
        input flag;
        input clrEv;
        input edgeMode;
        begin
            // level mode tracks the pin, so only edge mode holds
            irqNext = setEv | (flag & ~clrEv & edgeMode);
        end
    endfunction

    // ============================================================
    // pad drive and pulls
    // spi pins take the peripheral's drive while spi is enabled
    wire [9:0]  altMask = spiEn ? 10'h078 : 10'h000;
    wire [9:0]  altOut  = {3'h0, spiOut, 3'h0};
    wire [9:0]  altOe   = {3'h0, spiOe, 3'h0};

    // a pin is an output when its direction bit is 0
    assign pinOut = (altMask & altOut) | (~altMask & pinData);
    assign pinOe  = (altMask & altOe) | (~altMask & ~pinDir);
    // pull only on undriven inputs whose out bit is set
    wire [9:0]  pullOn = ~pinOe & pinDir & pinData;
    assign pullUpEn   = pullOn & ~pinPull;
    assign pullDownEn = pullOn & pinPull;

    // spi receives the filtered pin levels
    assign spiIn = pinFilt_q[6:3];

    // ============================================================
    // sync: three flops, a change is taken once stage 2 and 3 agree
    // the price is four clocks of input latency; in exchange a pulse
    // of one clock never reaches the data-in registers or the irqs
    // filtered levels start low; pads settle within four clocks
    always @(posedge core_clk) begin
        if (!rst_n) begin
            syncA_q   <= 10'h000;
            syncB_q   <= 10'h000;
            syncC_q   <= 10'h000;
            pinFilt_q <= 10'h000;
            pinPrev_q <= 10'h000;
        end else begin
            syncA_q   <= pinIn;
            syncB_q   <= syncA_q;
            syncC_q   <= syncB_q;
            // a one-cycle glitch never shows in both stages
            pinFilt_q <= (syncB_q & syncC_q) |
                         (pinFilt_q & (syncB_q | syncC_q));
            pinPrev_q <= pinFilt_q;
        end
    end

    // ============================================================
    // wake-up: sources 2..7 on PP3, PP4, PP6, PP7, PP8, PP9
    // the request is a plain level: it drops as soon as the pin, the
    // mask or the power-down input changes; nothing is latched here
    wire [5:0]  wakePin  = {pinFilt_q[9:6], pinFilt_q[4:3]};
    wire [5:0]  wakeLvl  = {pinPull[9:6], pinPull[4:3]};
    wire [5:0]  wakeIn   = {pinDir[9:6], pinDir[4:3]};
    // level matches when pin equals the pull select bit
    wire [5:0]  wakeHit  = ~(wakePin ^ wakeLvl) & wakeIn &
                           ~wakeMask_q[7:2];
    assign wakeReq = powerDown & (|wakeHit);

    // ============================================================
    // external interrupts
    // level mode re-evaluates every clock and edge mode latches the
    // flag until software or the controller clears it; a falling edge
    // is one clock wide because it compares against pinPrev_q
    wire        irqZeroEdge = irqCtrl_q[`DPG_IRQ_ZERO_EDGE];
    wire        irqOneEdge  = irqCtrl_q[`DPG_IRQ_ONE_EDGE];
    wire        fallZero    = pinPrev_q[9] & ~pinFilt_q[9];
    wire        fallOne     = pinPrev_q[7] & ~pinFilt_q[7];
    wire        setZero     = irqCtrl_q[`DPG_IRQ_ZERO_EN] &
                              (irqZeroEdge ? fallZero : ~pinFilt_q[9]);
    wire        setOne      = irqCtrl_q[`DPG_IRQ_ONE_EN] &
                              (irqOneEdge ? fallOne : ~pinFilt_q[7]);
    assign irqZeroFlag = irqZeroFlag_q;
    assign irqOneFlag  = irqOneFlag_q;

    // ============================================================
    // timer one pins
    // gate set: timer runs only while PP8 is high
    assign timerOneGateOk = ~altCtrl_q[`DPG_ALT_T1_GATE] |
                            pinFilt_q[8];
    // counter mode counts PP9 falling edges, else every clock
    assign timerOneCountTick = altCtrl_q[`DPG_ALT_T1_COUNT_SEL] ?
                               fallZero : 1'b1;

    // ============================================================
    // axi4-lite write side
    // only the low byte lane carries data; other lanes are ignored
    // one write is in flight at a time: each ready output drops once its half
    // is held and stays low until the held halves are committed
    assign s_axi_awready = ~awHeld_q;
    assign s_axi_wready  = ~wHeld_q;
    wire        doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
    wire        wrHit   = doWrite & wLane_q;
    wire        swClrZero = wrHit & (awIdx_q == `DPG_IDX_IRQ_CTRL) &
                            wByte_q[`DPG_IRQ_ZERO_FLAG];
    wire        swClrOne  = wrHit & (awIdx_q == `DPG_IDX_IRQ_CTRL) &
                            wByte_q[`DPG_IRQ_ONE_FLAG];

    // address and data are taken in either order, then answered
    always @(posedge core_clk) begin
        if (!rst_n) begin
            awHeld_q     <= 1'b0;
            wHeld_q      <= 1'b0;
            awIdx_q      <= 8'h00;
            wByte_q      <= 8'h00;
            wLane_q      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `DPG_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !awHeld_q) begin
                awHeld_q <= 1'b1;
                awIdx_q  <= s_axi_awaddr[9:2];
            end
            if (s_axi_wvalid && !wHeld_q) begin
                wHeld_q <= 1'b1;
                wByte_q <= s_axi_wdata[7:0];
                wLane_q <= s_axi_wstrb[0];
            end
            if (doWrite) begin
                // both halves present: commit and answer
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= isMapped(awIdx_q) ? `DPG_RESP_OKAY :
                                                    `DPG_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ============================================================
    // register updates and interrupt flags
    // the high port keeps only two bits; writes to reserved bits are
    // dropped so they always read back as zero
    // registers keep their value through power-down; only reset
    // loads the defaults
    always @(posedge core_clk) begin
        if (!rst_n) begin
            lowOut_q      <= `DPG_RST_LOW_OUT;
            lowDir_q      <= `DPG_RST_LOW_DIR;
            lowPull_q     <= `DPG_RST_LOW_PULL;
            highOut_q     <= `DPG_RST_HIGH_OUT;
            highDir_q     <= `DPG_RST_HIGH_DIR;
            highPull_q    <= `DPG_RST_HIGH_PULL;
            wakeMask_q    <= `DPG_RST_WAKE_MASK;
            irqCtrl_q     <= `DPG_RST_IRQ_CTRL;
            altCtrl_q     <= `DPG_RST_ALT_CTRL;
            irqZeroFlag_q <= 1'b0;
            irqOneFlag_q  <= 1'b0;
        end else begin
            if (wrHit) begin
                case (awIdx_q)
                    `DPG_IDX_LOW_PORT_OUT:   lowOut_q   <= wByte_q;
                    `DPG_IDX_LOW_PORT_DIR:   lowDir_q   <= wByte_q;
                    `DPG_IDX_LOW_PORT_PULL:  lowPull_q  <= wByte_q;
                    // upper six bits of the high port are dropped
                    `DPG_IDX_HIGH_PORT_OUT:  highOut_q  <= wByte_q[1:0];
                    `DPG_IDX_HIGH_PORT_DIR:  highDir_q  <= wByte_q[1:0];
                    `DPG_IDX_HIGH_PORT_PULL: highPull_q <= wByte_q[1:0];
                    `DPG_IDX_WAKE_MASK:      wakeMask_q <= wByte_q;
                    `DPG_IDX_IRQ_CTRL:       irqCtrl_q  <= wByte_q[3:0];
                    `DPG_IDX_ALT_CTRL:       altCtrl_q  <= wByte_q;
                    // input registers and holes ignore writes
                    default: ;
                endcase
            end
            irqZeroFlag_q <= irqNext(setZero, irqZeroFlag_q,
                                     swClrZero | irqZeroAck,
                                     irqZeroEdge);
            irqOneFlag_q  <= irqNext(setOne, irqOneFlag_q,
                                     swClrOne | irqOneAck,
                                     irqOneEdge);
        end
    end

    // ============================================================
    // read mux
    reg  [7:0]  rdByte;
    always @* begin
        case (s_axi_araddr[9:2])
            `DPG_IDX_LOW_PORT_OUT:   rdByte = lowOut_q;
            `DPG_IDX_LOW_PORT_DIR:   rdByte = lowDir_q;
            `DPG_IDX_LOW_PORT_IN:    rdByte = pinFilt_q[7:0];
            `DPG_IDX_LOW_PORT_PULL:  rdByte = lowPull_q;
            `DPG_IDX_HIGH_PORT_OUT:  rdByte = {6'h00, highOut_q};
            `DPG_IDX_HIGH_PORT_DIR:  rdByte = {6'h00, highDir_q};
            `DPG_IDX_HIGH_PORT_IN:   rdByte = {6'h00, pinFilt_q[9:8]};
            `DPG_IDX_HIGH_PORT_PULL: rdByte = {6'h00, highPull_q};
            `DPG_IDX_WAKE_MASK:      rdByte = wakeMask_q;
            `DPG_IDX_IRQ_CTRL:       rdByte = {2'h0, irqOneFlag_q,
                                               irqZeroFlag_q, irqCtrl_q};
            `DPG_IDX_ALT_CTRL:       rdByte = altCtrl_q;
            default:                 rdByte = 8'h00;
        endcase
    end

    // ============================================================
    // axi4-lite read side: one cycle from address to data
    // rdata is loaded from the mux at the edge that takes the address,
    // so the mux must follow araddr combinationally
    assign s_axi_arready = ~s_axi_rvalid;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `DPG_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rdByte};
            s_axi_rresp  <= isMapped(s_axi_araddr[9:2]) ?
                            `DPG_RESP_OKAY : `DPG_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // dpg_gpio_top

// ===== verif/dpg_gpio_properties.sv
// port-level checks of the dual-port gpio block
`timescale 1ns/1ps
module dpg_gpio_properties (
    input wire        core_clk,
    input wire        rst_n,
    input wire [9:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [9:0]  pinIn,
    input wire [9:0]  pinOe,
    input wire [9:0]  pullUpEn,
    input wire [9:0]  pullDownEn,
    input wire [3:0]  spiIn,
    input wire        powerDown,
    input wire        wakeReq,
    input wire        irqZeroFlag,
    input wire        irqOneFlag
);
    // ========
    // one clock domain, synchronous active-low reset
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // read address accepted at this edge
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // accepted read aimed at a two-bit high-port register
    sequence rdHigh;
        rdTaken ##0 (s_axi_araddr[9:2] inside {8'hB0, 8'hEB, 8'hEC, 8'hED});
    endsequence
    read_latency_a: assert property (rdTaken |=> s_axi_rvalid)
        else $error("read answer missing");
    high_zero_a: assert property (rdHigh |=> s_axi_rdata[31:2] == '0)
        else $error("high port reserved bits set");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("write answer dropped");
    pull_excl_a: assert property ((pullUpEn & pullDownEn) == '0)
        else $error("both pulls on");
    pull_input_a: assert property
        (((pullUpEn | pullDownEn) & pinOe) == '0)
        else $error("pull on a driven pin");
    reset_state_a: assert property ($rose(rst_n)
        |-> pinOe == '0 && pullDownEn == '0) else $error("pins not inputs");
    wake_pd_a: assert property (wakeReq |-> powerDown)
        else $error("wake outside power-down");
    filter_pass_a: assert property ($stable(pinIn[3]) [*8]
        |-> spiIn[0] == pinIn[3]) else $error("steady input not passed");
    irq_zero_src_a: assert property ($rose(irqZeroFlag)
        |-> !$past(pinIn[9], 4) || !$past(pinIn[9], 5) || !$past(pinIn[9], 6))
        else $error("irq zero without low pin");
    irq_one_src_a: assert property ($rose(irqOneFlag)
        |-> !$past(pinIn[7], 4) || !$past(pinIn[7], 5) || !$past(pinIn[7], 6))
        else $error("irq one without low pin");
endmodule // dpg_gpio_properties

bind dpg_gpio_top dpg_gpio_properties u_props (.core_clk, .rst_n,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .pinIn,
    .pinOe, .pullUpEn, .pullDownEn, .spiIn, .powerDown, .wakeReq,
    .irqZeroFlag, .irqOneFlag);

// ===== verif/dpg_pad_model.sv
// board-side model of the ten pads: drivers, pulls, floating lines
`timescale 1ns/1ps
module dpg_pad_model (
    input  wire       core_clk,
    input  wire [9:0] pinOut,
    input  wire [9:0] pinOe,
    input  wire [9:0] pullUpEn,
    input  wire [9:0] pullDownEn,
    input  wire [9:0] extVal,
    input  wire [9:0] extEn,
    output wire [9:0] pinLvl
);
    // ========
    // a free line wanders each cycle so it never reads as settled
    logic [9:0] wander_q = 10'h155;
    always @(posedge core_clk) begin
        wander_q <= ~wander_q;
    end
    // the block's driver wins, then the board, then the weak pulls
    assign pinLvl = (pinOe & pinOut) | (~pinOe & extEn & extVal)
        | (~pinOe & ~extEn & (pullUpEn | (~pullDownEn & wander_q)));
endmodule // dpg_pad_model

// ===== verif/dpg_gpio_bench.sv
// self-checking bench of the dual-port gpio block
`timescale 1ns/1ps
module dpg_gpio_bench;
    // ========
    // stimulus, answers and bookkeeping
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [9:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 4'hF, spiOut = '0, spiOe = '0, spiIn;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, powerDown = 0;
    logic        irqZeroAck = 0, irqOneAck = 0;
    logic [9:0]  extVal = '0, extEn = '0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, wakeReq, irqZeroFlag, irqOneFlag;
    logic        timerOneGateOk, timerOneCountTick;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [9:0]  pinIn, pinOut, pinOe, pullUpEn, pullDownEn;
    int          errTotal = 0, checked = 0, n;
    // rows: index, written byte, expected read-back
    logic [23:0] rows [7] = '{24'h90_5A5A, 24'h91_3C3C, 24'h93_A5A5,
        24'hB0_FE02, 24'hEB_FD01, 24'hED_FF03, 24'hF0_8181};
    // reset values, then the all-input pulled-up setup
    logic [15:0] rstRow [5] = '{16'h90FF, 16'h91FF, 16'hB003, 16'hEB03,
        16'h9300};
    logic [15:0] idle [6] = '{16'h91FF, 16'h90FF, 16'h9300, 16'hEB03,
        16'hB003, 16'hED00};
    int          wp [2:7] = '{3, 4, 6, 7, 8, 9};

    dpg_gpio_top dut (.*);
    dpg_pad_model pads (.core_clk, .pinOut, .pinOe, .pullUpEn, .pullDownEn,
        .extVal, .extEn, .pinLvl(pinIn));

    always #5 core_clk = ~core_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask

    // address and data offered together, each dropped once taken;
    // bready comes up after hold edges so a held answer is seen
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] rsp = 2'h0, input int hold = 0);
        int w;
        w = 0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= (hold == 0);
        do begin
            @(posedge core_clk);
            w++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (w == hold) s_axi_bready <= 1;
        end while (!(s_axi_bvalid && s_axi_bready));
        // bready stays up after the answer; only a next call with a hold drops it again
        chk(32'(s_axi_bresp), 32'(rsp));
    endtask

    // read one register and compare its word and its answer code
    task automatic rc(input logic [7:0] idx, input logic [7:0] exp,
                      input logic [1:0] rsp = 2'h0, input int hold = 0);
        int w;
        w = 0;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= (hold == 0);
        do begin
            @(posedge core_clk);
            w++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if (w == hold) s_axi_rready <= 1;
        end while (!(s_axi_rvalid && s_axi_rready));
        rv = s_axi_rdata;
        chk(rv, {24'h0, exp});
        chk(32'(s_axi_rresp), 32'(rsp));
    endtask

    // board drives one pad and waits out the input filter
    task automatic pin(input int p, input logic v);
        extEn[p] <= 1'b1;
        extVal[p] <= v;
        tick(8);
    endtask

    // a hang ends the run as a mismatch
    initial begin
        tick(20000);
        errTotal++;
        summarize();
    end

    initial begin
        tick(12);
        rst_n <= 1;
        tick(1);
        chk(32'(pinOe), 32'h0);
        chk(32'(pullUpEn), 32'h3FF);
        foreach (rstRow[i]) rc(rstRow[i][15:8], rstRow[i][7:0]);
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rc(rows[i][23:16], rows[i][7:0]);
        end
        $display("register table test done");
        // mixed directions: pins 0-3 in, 4-7 out, pin8 in, pin9 out
        wr(8'h91, 8'h0F);
        wr(8'h90, 8'h3D);
        wr(8'h93, 8'h08);
        chk(32'(pinOe), 32'h2F0);
        chk(32'(pinOut & pinOe), 32'h230);
        chk(32'(pullUpEn), 32'h005);
        chk(32'(pullDownEn), 32'h008);
        $display("pin config test done");
        foreach (idle[i]) wr(idle[i][15:8], idle[i][7:0]);
        wr(8'h92, 8'h00);
        rc(8'h92, 8'hFF);
        rc(8'hEC, 8'h03);
        extEn[0] <= 1'b1;
        tick(1);
        extVal[0] <= 1'b1;
        tick(8);
        rc(8'h92, 8'hFF);
        extVal[0] <= 1'b0;
        tick(5);
        rc(8'h92, 8'hFE);
        $display("input filter test done");
        powerDown <= 1;
        for (int b = 2; b < 8; b++) begin
            wr(8'hF0, ~(8'h01 << b));
            pin(wp[b], 0);
            chk(32'(wakeReq), 32'h1);
            wr(8'hF0, 8'hFF);
            chk(32'(wakeReq), 32'h0);
            pin(wp[b], 1);
        end
        wr(8'hF0, 8'h7F);
        wr(8'hED, 8'h02);
        pin(9, 0);
        chk(32'(wakeReq), 32'h0);
        pin(9, 1);
        chk(32'(wakeReq), 32'h1);
        powerDown <= 0;
        tick(1);
        chk(32'(wakeReq), 32'h0);
        wr(8'hF0, 8'hFF);
        wr(8'hED, 8'h00);
        $display("wake test done");
        wr(8'hF1, 8'h02);
        pin(9, 0);
        chk(32'(irqZeroFlag), 32'h0);
        pin(9, 1);
        wr(8'hF1, 8'h03);
        pin(9, 0);
        pin(9, 1);
        chk(32'(irqZeroFlag), 32'h1);
        rc(8'hF1, 8'h13);
        wr(8'hF1, 8'h13);
        chk(32'(irqZeroFlag), 32'h0);
        wr(8'hF1, 8'h04);
        pin(7, 0);
        chk(32'(irqOneFlag), 32'h1);
        pin(7, 1);
        chk(32'(irqOneFlag), 32'h0);
        wr(8'hF1, 8'h0C);
        pin(7, 0);
        chk(32'(irqOneFlag), 32'h1);
        irqOneAck <= 1;
        tick(1);
        irqOneAck <= 0;
        tick(1);
        chk(32'(irqOneFlag), 32'h0);
        pin(7, 1);
        wr(8'hF1, 8'h00);
        $display("interrupt test done");
        wr(8'hF2, 8'h80);
        pin(8, 0);
        chk(32'(timerOneGateOk), 32'h0);
        chk(32'(timerOneCountTick), 32'h1);
        wr(8'hF2, 8'h40);
        chk(32'(timerOneGateOk), 32'h1);
        extVal[9] <= 1'b0;
        n = 0;
        repeat (12) begin
            tick(1);
            if (timerOneCountTick === 1'b1) n++;
        end
        chk(n, 1);
        $display("timer pin test done");
        wr(8'hF2, 8'h01);
        spiOe <= 4'hA;
        spiOut <= 4'h8;
        extEn <= 10'h3AF;
        extVal <= 10'h3A7;
        tick(8);
        chk(32'(pinOe[6:3]), 32'hA);
        chk(32'(pinOut[6:3] & 4'hA), 32'h8);
        chk(32'(spiIn), 32'hC);
        wr(8'h91, 8'h00);
        chk(32'(pinOe[6:3]), 32'hA);
        chk(32'(pinOut[6:3] & 4'hA), 32'h8);
        wr(8'h10, 8'h00, 2'h2);
        rc(8'h10, 8'h00, 2'h2);
        wr(8'h90, 8'hC3, 2'h0, 3);
        rc(8'h90, 8'hC3, 2'h0, 3);
        $display("spi and decode test done");
        rst_n <= 0;
        tick(2);
        rst_n <= 1;
        tick(1);
        chk(32'(pinOe), 32'h0);
        rc(8'h91, 8'hFF);
        rc(8'h90, 8'hFF);
        $display("mid-run reset test done");
        summarize();
    end
endmodule // dpg_gpio_bench
